//--- dv/act_frame_model.sv
`timescale 1ns/100ps
// ****
// Frame sequencer stand-in: start pulse out, results back after a lag.
// ****
module act_frame_model (
    input wire logic aclk,
    input wire logic go,
    input wire logic [3:0] lag,
    input wire logic conv_start,
    output logic analog_phase_start,
    output logic results_ready,
    input wire logic analog_phase_end,
    input wire logic digital_phase_irq_enable,
    input wire logic frame_start_flag_clear,
    output logic digital_phase_irq
);
    logic [3:0] cnt_q;
    initial begin
        analog_phase_start = 1'h0;
        results_ready = 1'h0;
        cnt_q = 4'h0;
        digital_phase_irq = 1'h0;
    end
    always @(posedge aclk) begin
        analog_phase_start <= go;
        results_ready <= (cnt_q == 4'h1);
        if (conv_start === 1'h1)
            cnt_q <= lag;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
        if (frame_start_flag_clear === 1'h1)
            digital_phase_irq <= 1'h0;
        else if (analog_phase_end === 1'h1 && digital_phase_irq_enable === 1'h1)
            digital_phase_irq <= 1'h1;
    end
endmodule

//--- dv/act_top_checker.sv
`timescale 1ns/100ps
// ****
// Port checks for the trigger control block.
// ****
module act_top_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_start,
    input wire logic analog_phase_start,
    input wire logic analog_phase_end,
    input wire logic results_ready,
    input wire logic s_axi_bvalid,
    input wire logic completion_irq,
    input wire logic self_test_enable
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_start_cause; conv_start |-> $past(analog_phase_start) || s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_start_cause: assert property (p_start_cause) else $error("start without cause");
    property p_end_pulse; analog_phase_end |=> !analog_phase_end; endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("end pulse too long");
    property p_end_cause; analog_phase_end |-> $past(results_ready); endproperty
    a_end_cause: assert property (p_end_cause) else $error("end without results");
    property p_irq_reset; $rose(aresetn) |-> !completion_irq [*3]; endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
    property p_irq_rise;
        $rose(completion_irq) |-> $past(analog_phase_end, 2) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
    property p_irq_fall; $fell(completion_irq) |-> $past(conv_start) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
    property p_st_write; $changed(self_test_enable) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_st_write: assert property (p_st_write) else $error("self test changed without write");
endmodule
bind act_top act_top_checker u_act_top_checker (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
    .analog_phase_start(analog_phase_start), .analog_phase_end(analog_phase_end), .results_ready(results_ready),
    .s_axi_bvalid(s_axi_bvalid), .completion_irq(completion_irq), .self_test_enable(self_test_enable));

//--- dv/act_top_tb_top.sv
`timescale 1ns/100ps
// ****
// Bench for the conversion trigger control block.
// ****
module act_top_tb_top;
    logic aclk, aresetn, por_resetn, go;
    logic [3:0] lag, s_axi_wstrb;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic analog_phase_start, results_ready, conv_start, analog_phase_end, self_test_enable, completion_irq;
    logic digital_phase_irq_enable, frame_start_flag_clear, digital_phase_irq;
    int fail_count, checks, n_start, n_end;
    act_top u_act_top (.aclk, .aresetn, .por_resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_phase_start, .results_ready, .conv_start,
        .analog_phase_end, .self_test_enable, .completion_irq);
    act_frame_model u_act_frame_model (.aclk, .go, .lag, .conv_start, .analog_phase_start, .results_ready,
        .analog_phase_end, .digital_phase_irq_enable, .frame_start_flag_clear, .digital_phase_irq);
    initial begin
        aclk = 1'h0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (conv_start === 1'h1) n_start <= n_start + 1;
        if (analog_phase_end === 1'h1) n_end <= n_end + 1;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && s_axi_awready === 1'h1) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready === 1'h1) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rchk(input logic [7:0] a, input string nm, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        chk(nm, rd, exp);
    endtask
    task automatic hw_go;
        @(posedge aclk);
        go <= 1'h1;
        @(posedge aclk);
        go <= 1'h0;
    endtask
    task automatic t_regs;
        rchk(8'h00, "csr reset", 32'h0);
        chk("irq reset", completion_irq, 32'h0);
        rchk(8'h08, "hole read", 32'h0);
        chk("hole rresp", rs, 32'h2);
        wr(8'h08, 32'hff);
        chk("hole bresp", rs, 32'h2);
    endtask
    task automatic t_hw;
        wr(8'h00, 32'h2);
        cyc(3);
        chk("sw under hw", n_start, 32'h0);
        hw_go();
        cyc(3);
        chk("hw start", n_start, 32'h1);
        rchk(8'h04, "busy", 32'h1);
        cyc(12);
        rchk(8'h00, "done flag", 32'h4);
        chk("phase end", n_end, 32'h1);
        chk("irq off", completion_irq, 32'h0);
        chk("digital irq", digital_phase_irq, 32'h1);
        @(posedge aclk);
        frame_start_flag_clear <= 1'h1;
        @(posedge aclk);
        frame_start_flag_clear <= 1'h0;
        digital_phase_irq_enable <= 1'h0;
        cyc(1);
        chk("digital irq cleared", digital_phase_irq, 32'h0);
    endtask
    task automatic t_sw;
        wr(8'h00, 32'h1);
        rchk(8'h00, "zero keeps flag", 32'h5);
        wr(8'h00, 32'hb);
        rchk(8'h00, "strobe reads zero", 32'h9);
        cyc(14);
        chk("sw start", n_start, 32'h2);
        rchk(8'h00, "sw done", 32'hd);
        chk("irq on", completion_irq, 32'h1);
        hw_go();
        cyc(3);
        chk("hw under sw", n_start, 32'h2);
        wr(8'h00, 32'h9);
        rchk(8'h00, "flag kept", 32'hd);
        wr(8'h00, 32'hd);
        rchk(8'h00, "flag cleared", 32'h9);
        chk("irq cleared", completion_irq, 32'h0);
        lag <= 4'h1;
        wr(8'h00, 32'hb);
        cyc(6);
        chk("prompt start", n_start, 32'h3);
        chk("prompt irq", completion_irq, 32'h1);
        chk("end count", n_end, 32'h3);
        chk("digital irq gated", digital_phase_irq, 32'h0);
        wr(8'h00, 32'h4);
    endtask
    task automatic t_st;
        wr(8'h00, 32'h80);
        chk("csr bresp", rs, 32'h0);
        chk("self test on", self_test_enable, 32'h1);
        wr(8'h00, 32'h0);
        chk("self test off", self_test_enable, 32'h0);
    endtask
    task automatic t_trim;
        wr(8'h14, 32'ha5c3);
        wr(8'h00, 32'h88);
        @(posedge aclk);
        aresetn <= 1'h0;
        cyc(3);
        aresetn <= 1'h1;
        cyc(2);
        rchk(8'h14, "trim kept", 32'ha5c3);
        chk("trim rresp", rs, 32'h0);
        rchk(8'h00, "csr cleared", 32'h0);
    endtask
    task automatic test_done;
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        aresetn = 1'h0;
        por_resetn = 1'h0;
        go = 1'h0;
        digital_phase_irq_enable = 1'h1;
        frame_start_flag_clear = 1'h0;
        lag = 4'h8;
        s_axi_wstrb = 4'hf;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        cyc(20);
        aresetn <= 1'h1;
        por_resetn <= 1'h1;
        cyc(2);
        t_regs();
        t_hw();
        t_sw();
        t_st();
        t_trim();
        test_done();
    end
    initial begin
        #300000;
        fail_count++;
        test_done();
    end
endmodule

//--- rtl/act_consts.svh
`ifndef ACT_CONSTS_SVH
`define ACT_CONSTS_SVH
// Notes on behaviour
// - Self-test enable at one drives the self-test output that disturbs the measurement chain.
// - With completion interrupt enabled, interrupt follows the conversion-done flag.
// - Completion interrupt enable resets to zero.
// - Done flag reads one after a finished cycle, zero while converting; a start in the same cycle as cif.done leaves it at one.
// - Writing one clears the done flag; writing zero leaves it.
// - With software trigger type, writing one to the trigger bit starts conversions.
// - Trigger write ignored under hardware trigger type; writing zero never acts.
// - With trigger type zero, only the analog-phase start pulse starts conversions.
// - Block emits an end-of-analog-phase pulse, which is not an interrupt.
// - Of the two resets, only power-on reset touches the trim registers.

// ******************************************************************
// Register map.
// ******************************************************************
`define ACT_ADDR_W 8
`define ACT_CSR_OFS 8'h00
`define ACT_STAT_OFS 8'h04
`define ACT_TRIM_BASE 8'h10
`define ACT_TRIM_WORDS 4
`define ACT_TRIM_IDX_W 2
`define ACT_TRIM_W 16

// ******************************************************************
// Control and status fields.
// ******************************************************************
`define ACT_BIT_TT 0
`define ACT_BIT_SOFTWARE_TRIGGER 1
`define ACT_BIT_CONVERSION_DONE_FLAG 2
`define ACT_BIT_COMPLETION_IRQ_ENABLE 3
`define ACT_BIT_ST 7
`define ACT_BIT_BUSY 0
`define ACT_TRIM_RESET 16'h0000

// ******************************************************************
// Bus answers.
// ******************************************************************
`define ACT_RESP_OKAY 2'h0
`define ACT_RESP_SLVERR 2'h2
`endif

//--- rtl/act_conv_if.sv
`timescale 1ns/100ps
interface act_conv_if;
    logic start;
    logic busy;
    logic done;
    modport ctl (output start, input busy, input done);
    modport seq (input start, output busy, output done);
endinterface

//--- rtl/act_conv_seq.sv
`timescale 1ns/100ps
`include "act_consts.svh"
module act_conv_seq (
    input wire logic aclk,
    input wire logic aresetn,
    act_conv_if.seq cif,
    input wire logic results_ready,
    output logic conv_start_q,
    output logic phase_end_q
);
    act_pkg::act_state_e state_q;
    logic done_q;

    // ******************************************************************
    // Analog phase sequencing.
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= act_pkg::ACT_IDLE;
        end else begin
            unique case (state_q)
                act_pkg::ACT_IDLE: begin
                    if (cif.start) begin
                        state_q <= act_pkg::ACT_CONVERT;
                    end
                end
                act_pkg::ACT_CONVERT: begin
                    if (results_ready) begin
                        state_q <= act_pkg::ACT_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_start_q <= 1'b0;
            phase_end_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            conv_start_q <= (state_q == act_pkg::ACT_IDLE) && cif.start;
            done_q <= (state_q == act_pkg::ACT_CONVERT) && results_ready;
            phase_end_q <= (state_q == act_pkg::ACT_CONVERT) && results_ready;
        end
    end

    assign cif.busy = (state_q == act_pkg::ACT_CONVERT);
    assign cif.done = done_q;
endmodule

//--- rtl/act_pkg.sv
package act_pkg;
    typedef enum logic {
        ACT_IDLE,
        ACT_CONVERT
    } act_state_e;
    typedef logic [1:0] act_resp_t;
endpackage

//--- rtl/act_top.sv
`timescale 1ns/100ps
`include "act_consts.svh"
module act_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_resetn,
    input wire logic [`ACT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`ACT_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic analog_phase_start,
    input wire logic results_ready,
    output logic conv_start,
    output logic analog_phase_end,
    output logic self_test_enable,
    output logic completion_irq
);
    // ******************************************************************
    // Address decoding.
    // ******************************************************************
    function automatic logic is_trim(input logic [`ACT_ADDR_W-1:0] addr);
        is_trim = (addr[`ACT_ADDR_W-1:4] == 4'(`ACT_TRIM_BASE >> 4)) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic is_mapped(input logic [`ACT_ADDR_W-1:0] addr);
        is_mapped = is_trim(addr) || (addr == `ACT_CSR_OFS) || (addr == `ACT_STAT_OFS);
    endfunction

    act_conv_if cif ();

    logic awready_q;
    logic wready_q;
    logic aw_full_q;
    logic w_full_q;
    logic [`ACT_ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rd_pend_q;
    logic [`ACT_ADDR_W-1:0] raddr_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic tt_q;
    logic completion_irq_enable_q;
    logic st_q;
    logic conversion_done_flag_q;
    logic irq_q;
    logic commit;
    logic csr_wr;
    logic trim_wr;
    logic sw_start;
    logic hw_start;
    logic [`ACT_TRIM_W-1:0] trim_rd;

    // ******************************************************************
    // Write channels.
    // ******************************************************************
    assign commit = aw_full_q && w_full_q && !bvalid_q;
    assign csr_wr = commit && (waddr_q == `ACT_CSR_OFS) && wstrb_q[0];
    assign trim_wr = commit && is_trim(waddr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b0;
            waddr_q <= '0;
        end else if (awready_q && s_axi_awvalid) begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
        end else if (commit) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_full_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (wready_q && s_axi_wvalid) begin
            wready_q <= 1'b0;
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (commit) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `ACT_RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(waddr_q) ? `ACT_RESP_OKAY : `ACT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Read channels.
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rd_pend_q <= 1'b0;
            raddr_q <= '0;
        end else if (arready_q && s_axi_arvalid) begin
            arready_q <= 1'b0;
            rd_pend_q <= 1'b1;
            raddr_q <= s_axi_araddr;
        end else begin
            rd_pend_q <= 1'b0;
            if (!rd_pend_q && !rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `ACT_RESP_OKAY;
        end else if (rd_pend_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(raddr_q) ? `ACT_RESP_OKAY : `ACT_RESP_SLVERR;
            rdata_q <= '0;
            if (raddr_q == `ACT_CSR_OFS) begin
                rdata_q[`ACT_BIT_ST] <= st_q;
                rdata_q[`ACT_BIT_COMPLETION_IRQ_ENABLE] <= completion_irq_enable_q;
                rdata_q[`ACT_BIT_CONVERSION_DONE_FLAG] <= conversion_done_flag_q;
                rdata_q[`ACT_BIT_SOFTWARE_TRIGGER] <= 1'b0;
                rdata_q[`ACT_BIT_TT] <= tt_q;
            end else if (raddr_q == `ACT_STAT_OFS) begin
                rdata_q[`ACT_BIT_BUSY] <= cif.busy;
            end else if (is_trim(raddr_q)) begin
                rdata_q[`ACT_TRIM_W-1:0] <= trim_rd;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Control bits.
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tt_q <= 1'b0;
            completion_irq_enable_q <= 1'b0;
            st_q <= 1'b0;
        end else if (csr_wr) begin
            tt_q <= wdata_q[`ACT_BIT_TT];
            completion_irq_enable_q <= wdata_q[`ACT_BIT_COMPLETION_IRQ_ENABLE];
            st_q <= wdata_q[`ACT_BIT_ST];
        end
    end

    // ******************************************************************
    // Conversion start selection.
    // ******************************************************************
    assign sw_start = csr_wr && wdata_q[`ACT_BIT_SOFTWARE_TRIGGER] && tt_q;
    assign hw_start = analog_phase_start && !tt_q;
    assign cif.start = sw_start || hw_start;

    // ******************************************************************
    // Completion flag and interrupt.
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conversion_done_flag_q <= 1'b0;
        end else if (cif.done) begin
            conversion_done_flag_q <= 1'b1;
        end else if (cif.start && !cif.busy) begin
            conversion_done_flag_q <= 1'b0;
        end else if (csr_wr && wdata_q[`ACT_BIT_CONVERSION_DONE_FLAG]) begin
            conversion_done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= completion_irq_enable_q && conversion_done_flag_q;
        end
    end

    // ******************************************************************
    // Submodules.
    // ******************************************************************
    act_conv_seq u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif.seq),
        .results_ready(results_ready),
        .conv_start_q(conv_start),
        .phase_end_q(analog_phase_end)
    );

    act_trim_store u_trim (
        .aclk(aclk),
        .por_resetn(por_resetn),
        .wr_en(trim_wr),
        .wr_idx(waddr_q[`ACT_TRIM_IDX_W+1:2]),
        .wr_be(wstrb_q[1:0]),
        .wr_data(wdata_q[`ACT_TRIM_W-1:0]),
        .rd_idx(s_axi_araddr[`ACT_TRIM_IDX_W+1:2]),
        .rd_data_q(trim_rd)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign self_test_enable = st_q;
    assign completion_irq = irq_q;
endmodule

//--- rtl/act_trim_store.sv
`timescale 1ns/100ps
`include "act_consts.svh"
module act_trim_store (
    input wire logic aclk,
    input wire logic por_resetn,
    input wire logic wr_en,
    input wire logic [`ACT_TRIM_IDX_W-1:0] wr_idx,
    input wire logic [1:0] wr_be,
    input wire logic [`ACT_TRIM_W-1:0] wr_data,
    input wire logic [`ACT_TRIM_IDX_W-1:0] rd_idx,
    output logic [`ACT_TRIM_W-1:0] rd_data_q
);
    logic [`ACT_TRIM_W-1:0] mem_q [`ACT_TRIM_WORDS];

    // ******************************************************************
    // Storage cleared by power-on reset only.
    // ******************************************************************
    genvar gw;
    genvar gb;
    generate
        for (gw = 0; gw < `ACT_TRIM_WORDS; gw++) begin : g_word
            for (gb = 0; gb < 2; gb++) begin : g_byte
                always_ff @(posedge aclk) begin
                    if (!por_resetn) begin
                        mem_q[gw][gb*8 +: 8] <= 8'(`ACT_TRIM_RESET >> (gb * 8));
                    end else if (wr_en && wr_be[gb] && (wr_idx == `ACT_TRIM_IDX_W'(gw))) begin
                        mem_q[gw][gb*8 +: 8] <= wr_data[gb*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            rd_data_q <= `ACT_TRIM_RESET;
        end else begin
            rd_data_q <= mem_q[rd_idx];
        end
    end
endmodule
